// ===== pis_map.svh
// register offsets, field positions and timing counts of the two-wire link
`ifndef PIS_MAP_SVH
`define PIS_MAP_SVH
`define PIS_SYS_CLK_PS 5000
`define PIS_SCL_PERIOD_NS 1000
`define PIS_QUARTER_CYC ((`PIS_SCL_PERIOD_NS * 1000 + 4 * `PIS_SYS_CLK_PS - 1) / (4 * `PIS_SYS_CLK_PS))
`define PIS_REG_BASE_ADDR 8'h40
`define PIS_REG_PIN_CFG 8'h42
`define PIS_PIN_DIS_BIT 6
`define PIS_REG_ADDR_LOCK 8'hD4
`define PIS_ADDR_LOCK_BIT 2
`define PIS_CMD_VENDOR_WIN 8'hD0
`define PIS_REG_ACCESS 8'hD5
`define PIS_ACC_PW_EN 0
`define PIS_ACC_WR_PROT 1
`define PIS_ACC_RD_PROT 2
`define PIS_ACC_TELEM 3
`define PIS_REG_PASSWORD 8'hD6
`define PIS_CMD_UNLOCK 8'hD7
`define PIS_CMD_STORE 8'h15
`define PIS_TELEM_LO 8'h88
`define PIS_TELEM_HI 8'h97
`define PIS_CMD_VIN 8'h88
`define PIS_CMD_IIN 8'h89
`define PIS_CMD_VOUT 8'h8B
`define PIS_CMD_IOUT 8'h8C
`define PIS_CMD_TEMP 8'h8D
`define PIS_CMD_POUT 8'h96
`define PIS_CMD_PIN 8'h97
`define PIS_NV_LOW_BASE 8'h40
`define PIS_NV_HIGH_BASE 8'hD0
`define PIS_CRC_POLY 16'h1021
`define PIS_CRC_INIT 16'hFFFF
`define PIS_HREG_CTRL 8'h00
`define PIS_HREG_SLAVE 8'h04
`define PIS_HREG_CMD 8'h08
`define PIS_HREG_WDATA 8'h0C
`define PIS_HREG_RDATA 8'h10
`define PIS_HREG_STATUS 8'h14
`endif

// ===== pis_pkg.sv
// types shared by both ends of the two-wire link
`default_nettype none
package pis_pkg;
  typedef enum logic [2:0] {PIS_S_IDLE, PIS_S_ADDR, PIS_S_CMD, PIS_S_WR, PIS_S_RD} pis_slv_t;
  typedef enum logic [2:0] {PIS_B_LOAD, PIS_B_RUN, PIS_B_STORE, PIS_B_FAIL} pis_boot_t;
  typedef enum logic [1:0] {PIS_Y_START, PIS_Y_TX, PIS_Y_RX, PIS_Y_STOP} pis_sym_t;
  typedef enum logic [1:0] {PIS_M_WRITE, PIS_M_READ, PIS_M_SEND} pis_mode_t;
endpackage
`default_nettype wire

// ===== pis_link_if.sv
// open-drain clock and data wires between host and device
`timescale 1ns/1ps
`default_nettype none
interface pis_link_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  modport host (output host_scl_o, output host_scl_oe_n, output host_sda_o,
                output host_sda_oe_n, input scl, input sda);
  modport dev (output dev_sda_o, output dev_sda_oe_n, input scl, input sda);
endinterface
`default_nettype wire

// ===== pis_dev_end.sv
// device end: two-wire slave with address forming, access control and config store
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pis_map.svh"
module pis_dev_end #(
  parameter int NV_WORDS = 16
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  pis_link_if.dev          link,
  input  wire logic [2:0]  address_offset_select_pin,
  input  wire logic [15:0] tele_vin,
  input  wire logic [15:0] tele_iin,
  input  wire logic [15:0] tele_vout,
  input  wire logic [15:0] tele_iout,
  input  wire logic [15:0] tele_temp,
  input  wire logic [15:0] tele_pout,
  input  wire logic [15:0] tele_pin,
  output logic [7:0]       nv_addr,
  output logic             nv_we,
  output logic [15:0]      nv_wdata,
  input  wire logic [15:0] nv_rdata,
  output logic             dev_ready,
  output logic             boot_fail,
  output logic             pmbus_enabled,
  output logic             test_mode,
  output logic             pin_offset_used
);
  localparam logic [7:0] NV_LAST = 8'(NV_WORDS);

  function automatic logic [15:0] pis_crc16(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int k = 0; k < 16; k++) begin
      r = (r[15] ^ d[15 - k]) ? ({r[14:0], 1'b0} ^ `PIS_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [7:0] pis_nv_idx(input logic [7:0] i);
    return (i < 8'h08) ? 8'(`PIS_NV_LOW_BASE + i) : 8'(`PIS_NV_HIGH_BASE + i - 8'h08);
  endfunction

  function automatic logic pis_access_ok(input logic [7:0] t, input logic w,
                                         input logic [3:0] acc, input logic unl);
    logic tel;
    tel = (t >= `PIS_TELEM_LO) && (t <= `PIS_TELEM_HI);
    if (acc[`PIS_ACC_PW_EN] && !unl) return w && (t == `PIS_CMD_UNLOCK);
    if (acc[`PIS_ACC_TELEM]) return !w && tel;
    if (w) return !acc[`PIS_ACC_WR_PROT];
    return !acc[`PIS_ACC_RD_PROT] || tel;
  endfunction

  logic [15:0]     regs [0:255];
  pis_pkg::pis_boot_t boot_st;
  pis_pkg::pis_slv_t  st;
  logic [7:0]  bptr;
  logic [15:0] crc;
  logic [2:0]  osync [0:2];
  logic [2:0]  offset;
  logic [2:0]  scl_s;
  logic [2:0]  sda_s;
  logic        f_scl;
  logic        f_sda;
  logic        p_scl;
  logic        p_sda;
  logic [3:0]  bcnt;
  logic        in_ack;
  logic [7:0]  shreg;
  logic        is_rd;
  logic [7:0]  cmd;
  logic [7:0]  ptr;
  logic [1:0]  nbyte;
  logic [7:0]  wlo;
  logic [15:0] rd_word;
  logic [1:0]  rbyte;
  logic        mnack;
  logic        unlocked;

  wire run       = (boot_st == pis_pkg::PIS_B_RUN);
  wire scl_rise  = f_scl & ~p_scl;
  wire scl_fall  = ~f_scl & p_scl;
  wire start_c   = p_scl & f_scl & p_sda & ~f_sda;
  wire stop_c    = p_scl & f_scl & ~p_sda & f_sda;
  wire byte_end  = scl_fall & ~in_ack & (bcnt == 4'd8);
  wire [6:0] i2c_base = regs[`PIS_REG_BASE_ADDR][14:8];
  wire [6:0] pmb_base = regs[`PIS_REG_BASE_ADDR][6:0];
  wire pin_dis   = regs[`PIS_REG_PIN_CFG][`PIS_PIN_DIS_BIT];
  wire addr_lock = regs[`PIS_REG_ADDR_LOCK][`PIS_ADDR_LOCK_BIT];
  wire [3:0] acc = regs[`PIS_REG_ACCESS][3:0];
  wire [15:0] password = regs[`PIS_REG_PASSWORD];
  wire [6:0] eff_i2c = pin_dis ? i2c_base : i2c_base + {4'b0000, offset};
  wire [6:0] eff_pmb = pin_dis ? pmb_base : pmb_base + {4'b0000, offset};
  wire pmb_on    = (pmb_base != 7'h00);
  wire addr_hit  = run & ((shreg[7:1] == eff_i2c) | (pmb_on & (shreg[7:1] == eff_pmb)));
  wire vend      = (cmd == `PIS_CMD_VENDOR_WIN);
  wire [7:0] target = vend ? ptr : cmd;
  wire wr_ok     = pis_access_ok(target, 1'b1, acc, unlocked);
  wire rd_ok     = pis_access_ok(target, 1'b0, acc, unlocked);
  wire addr_prot = addr_lock & ((target == `PIS_REG_BASE_ADDR) | (target == `PIS_REG_PIN_CFG));
  wire [1:0] last_idx = vend ? 2'd2 : 2'd1;
  wire ptr_byte  = vend & (nbyte == 2'd0);
  wire wr_ack    = run & (nbyte <= last_idx) & (ptr_byte | wr_ok);
  wire last_byte = (nbyte == last_idx);
  wire unlock_cmd = (target == `PIS_CMD_UNLOCK);
  wire commit_now = byte_end & (st == pis_pkg::PIS_S_WR) & run & last_byte & wr_ok
                    & ~addr_prot & ~unlock_cmd;
  wire store_go  = byte_end & (st == pis_pkg::PIS_S_CMD) & run & (shreg == `PIS_CMD_STORE)
                   & pis_access_ok(`PIS_CMD_STORE, 1'b1, acc, unlocked);
  wire [15:0] rd_value = (target == `PIS_CMD_VIN)  ? tele_vin  :
                         (target == `PIS_CMD_IIN)  ? tele_iin  :
                         (target == `PIS_CMD_VOUT) ? tele_vout :
                         (target == `PIS_CMD_IOUT) ? tele_iout :
                         (target == `PIS_CMD_TEMP) ? tele_temp :
                         (target == `PIS_CMD_POUT) ? tele_pout :
                         (target == `PIS_CMD_PIN)  ? tele_pin  : regs[target];
  wire [15:0] rd_first = rd_ok ? rd_value : 16'hFFFF;
  wire [7:0] tx_cur = (rbyte == 2'd0) ? rd_word[7:0] : (rbyte == 2'd1) ? rd_word[15:8] : 8'hFF;
  wire [7:0] tx_nxt = (rbyte == 2'd0) ? rd_word[15:8] : 8'hFF;

  // image load at boot, CRC gate, register writes and image programming
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_st  <= pis_pkg::PIS_B_LOAD;
      nv_addr  <= 8'h00;
      nv_we    <= 1'b0;
      nv_wdata <= 16'h0000;
      crc      <= `PIS_CRC_INIT;
      bptr     <= 8'h00;
      offset   <= 3'b000;
    end else begin
      case (boot_st)
        pis_pkg::PIS_B_LOAD: begin
          if (nv_addr == NV_LAST) begin
            offset  <= osync[2];
            boot_st <= (crc == nv_rdata) ? pis_pkg::PIS_B_RUN : pis_pkg::PIS_B_FAIL;
          end else begin
            regs[pis_nv_idx(nv_addr)] <= nv_rdata;
            crc     <= pis_crc16(crc, nv_rdata);
            nv_addr <= nv_addr + 8'h01;
          end
        end
        pis_pkg::PIS_B_RUN: begin
          if (commit_now) regs[target] <= {shreg, wlo};
          if (store_go) begin
            boot_st <= pis_pkg::PIS_B_STORE;
            bptr    <= 8'h00;
            crc     <= `PIS_CRC_INIT;
          end
        end
        pis_pkg::PIS_B_STORE: begin
          if (bptr > NV_LAST) begin
            nv_we   <= 1'b0;
            boot_st <= pis_pkg::PIS_B_RUN;
          end else begin
            nv_we    <= 1'b1;
            nv_addr  <= bptr;
            nv_wdata <= (bptr == NV_LAST) ? crc : regs[pis_nv_idx(bptr)];
            crc      <= pis_crc16(crc, regs[pis_nv_idx(bptr)]);
            bptr     <= bptr + 8'h01;
          end
        end
        default: nv_we <= 1'b0;
      endcase
    end
  end

  // three-stage sampling of the wires and the strap; a wire change counts when stages 2 and 3 agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_s <= 3'b111;
      sda_s <= 3'b111;
      f_scl <= 1'b1;
      f_sda <= 1'b1;
      p_scl <= 1'b1;
      p_sda <= 1'b1;
      for (int i = 0; i < 3; i++) osync[i] <= 3'b000;
    end else begin
      scl_s <= {scl_s[1:0], link.scl};
      sda_s <= {sda_s[1:0], link.sda};
      osync[0] <= address_offset_select_pin;
      osync[1] <= osync[0];
      osync[2] <= osync[1];
      if (scl_s[1] == scl_s[2]) f_scl <= scl_s[2];
      if (sda_s[1] == sda_s[2]) f_sda <= sda_s[2];
      p_scl <= f_scl;
      p_sda <= f_sda;
    end
  end

  // byte engine: shift on clock rise, drive data and acknowledge on clock fall
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= pis_pkg::PIS_S_IDLE;
      {bcnt, in_ack, shreg, is_rd, cmd, ptr, nbyte, wlo} <= '0;
      {rd_word, rbyte, mnack, unlocked} <= '0;
      link.dev_sda_oe_n <= 1'b1;
    end else if (start_c) begin
      st     <= pis_pkg::PIS_S_ADDR;
      bcnt   <= 4'd0;
      in_ack <= 1'b0;
      link.dev_sda_oe_n <= 1'b1;
    end else if (stop_c) begin
      st <= pis_pkg::PIS_S_IDLE;
      link.dev_sda_oe_n <= 1'b1;
    end else if (scl_rise && st != pis_pkg::PIS_S_IDLE) begin
      if (in_ack) mnack <= f_sda;
      else begin
        shreg <= {shreg[6:0], f_sda};
        bcnt  <= bcnt + 4'd1;
      end
    end else if (byte_end) begin
      in_ack <= 1'b1;
      link.dev_sda_oe_n <= 1'b1;
      case (st)
        pis_pkg::PIS_S_ADDR: begin
          is_rd <= shreg[0];
          if (addr_hit) link.dev_sda_oe_n <= 1'b0;
          else st <= pis_pkg::PIS_S_IDLE;
        end
        pis_pkg::PIS_S_CMD: begin
          cmd   <= shreg;
          nbyte <= 2'd0;
          link.dev_sda_oe_n <= 1'b0;
        end
        pis_pkg::PIS_S_WR: begin
          link.dev_sda_oe_n <= ~wr_ack;
          if (wr_ack && ptr_byte) ptr <= shreg;
          else if (wr_ack && !last_byte) wlo <= shreg;
          if (wr_ack && last_byte && unlock_cmd) unlocked <= ({shreg, wlo} == password);
        end
        default: ;
      endcase
    end else if (scl_fall && in_ack) begin
      in_ack <= 1'b0;
      bcnt   <= 4'd0;
      link.dev_sda_oe_n <= 1'b1;
      case (st)
        pis_pkg::PIS_S_ADDR: begin
          if (is_rd) begin
            st      <= pis_pkg::PIS_S_RD;
            rd_word <= rd_first;
            rbyte   <= 2'd0;
            link.dev_sda_oe_n <= rd_first[7];
          end else st <= pis_pkg::PIS_S_CMD;
        end
        pis_pkg::PIS_S_CMD: st <= pis_pkg::PIS_S_WR;
        pis_pkg::PIS_S_WR: if (nbyte != 2'd3) nbyte <= nbyte + 2'd1;
        pis_pkg::PIS_S_RD: begin
          if (mnack) st <= pis_pkg::PIS_S_IDLE;
          else begin
            if (rbyte != 2'd3) rbyte <= rbyte + 2'd1;
            link.dev_sda_oe_n <= tx_nxt[7];
          end
        end
        default: ;
      endcase
    end else if (scl_fall && st == pis_pkg::PIS_S_RD && bcnt < 4'd8) begin
      link.dev_sda_oe_n <= tx_cur[3'(4'd7 - bcnt)];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.dev_sda_o  <= 1'b0;
      dev_ready       <= 1'b0;
      boot_fail       <= 1'b0;
      pmbus_enabled   <= 1'b0;
      test_mode       <= 1'b0;
      pin_offset_used <= 1'b0;
    end else begin
      link.dev_sda_o  <= 1'b0;
      dev_ready       <= run;
      boot_fail       <= (boot_st == pis_pkg::PIS_B_FAIL);
      pmbus_enabled   <= run & pmb_on;
      test_mode       <= run & (i2c_base == 7'h00);
      pin_offset_used <= run & ~pin_dis;
    end
  end
endmodule
`default_nettype wire

// ===== pis_host_end.sv
// host end: AHB-Lite command registers driving a two-wire bus master
`timescale 1ns/1ps
`default_nettype none
`include "pis_map.svh"
module pis_host_end #(
  parameter int QUARTER_CYC = `PIS_QUARTER_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  pis_link_if.host         link,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);
  logic [6:0]  slave_addr;
  logic [7:0]  cmd_code;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        busy;
  logic        nack;
  pis_pkg::pis_mode_t mode;
  logic        dp_wr;
  logic [7:0]  dp_addr;
  logic [15:0] qcnt;
  logic [1:0]  q;
  logic [2:0]  sym;
  logic [3:0]  bitn;
  logic        stopping;
  logic [7:0]  rx;
  logic [2:0]  sda_s;
  logic        f_sda;

  wire take    = hsel & htrans[1] & hready;
  wire go_wr   = dp_wr & (dp_addr == `PIS_HREG_CTRL) & hwdata[0] & ~busy;
  wire is_rd   = (mode == pis_pkg::PIS_M_READ);
  wire tick    = busy & (qcnt == 16'h0000);
  wire at_stop = stopping | (sym == 3'd7) | ((mode == pis_pkg::PIS_M_WRITE) & (sym == 3'd5))
                 | ((mode == pis_pkg::PIS_M_SEND) & (sym == 3'd3));
  wire pis_pkg::pis_sym_t kind = at_stop ? pis_pkg::PIS_Y_STOP :
                                 ((sym == 3'd0) | (is_rd & (sym == 3'd3))) ? pis_pkg::PIS_Y_START :
                                 (is_rd & (sym >= 3'd5)) ? pis_pkg::PIS_Y_RX : pis_pkg::PIS_Y_TX;
  wire [7:0] txb = (sym == 3'd1) ? {slave_addr, 1'b0} :
                   (sym == 3'd2) ? cmd_code :
                   (sym == 3'd3) ? wdata[7:0] :
                   is_rd ? {slave_addr, 1'b1} : wdata[15:8];
  wire [31:0] rd_mux = (haddr == `PIS_HREG_SLAVE)  ? {25'h000_0000, slave_addr} :
                       (haddr == `PIS_HREG_CMD)    ? {24'h00_0000, cmd_code} :
                       (haddr == `PIS_HREG_WDATA)  ? {16'h0000, wdata} :
                       (haddr == `PIS_HREG_RDATA)  ? {16'h0000, rdata} :
                       (haddr == `PIS_HREG_STATUS) ? {30'h0000_0000, nack, busy} : 32'h0000_0000;

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0000_0000;
      dp_wr      <= 1'b0;
      dp_addr    <= 8'h00;
      slave_addr <= 7'h00;
      cmd_code   <= 8'h00;
      wdata      <= 16'h0000;
      mode       <= pis_pkg::PIS_M_WRITE;
    end else begin
      dp_wr   <= take & hwrite;
      dp_addr <= haddr;
      if (take && !hwrite) hrdata <= rd_mux;
      if (dp_wr && dp_addr == `PIS_HREG_SLAVE) slave_addr <= hwdata[6:0];
      if (dp_wr && dp_addr == `PIS_HREG_CMD) cmd_code <= hwdata[7:0];
      if (dp_wr && dp_addr == `PIS_HREG_WDATA) wdata <= hwdata[15:0];
      if (go_wr) mode <= pis_pkg::pis_mode_t'(hwdata[2:1]);
    end
  end

  // data line sampled through three stages
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sda_s <= 3'b111;
      f_sda <= 1'b1;
    end else begin
      sda_s <= {sda_s[1:0], link.sda};
      if (sda_s[1] == sda_s[2]) f_sda <= sda_s[2];
    end
  end

  // symbol engine: each start, bit or stop takes four quarter periods of the bus clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy     <= 1'b0;
      nack     <= 1'b0;
      rdata    <= 16'h0000;
      qcnt     <= 16'h0000;
      q        <= 2'd0;
      sym      <= 3'd0;
      bitn     <= 4'd0;
      stopping <= 1'b0;
      rx       <= 8'h00;
      link.host_scl_o    <= 1'b0;
      link.host_sda_o    <= 1'b0;
      link.host_scl_oe_n <= 1'b1;
      link.host_sda_oe_n <= 1'b1;
    end else if (go_wr) begin
      busy     <= 1'b1;
      nack     <= 1'b0;
      qcnt     <= 16'(QUARTER_CYC - 1);
      {q, sym, bitn, stopping} <= '0;
    end else if (busy) begin
      qcnt <= tick ? 16'(QUARTER_CYC - 1) : qcnt - 16'h0001;
      if (tick) begin
        q <= q + 2'd1;
        case (kind)
          pis_pkg::PIS_Y_START: begin
            if (q == 2'd0) link.host_sda_oe_n <= 1'b1;
            if (q == 2'd1) link.host_scl_oe_n <= 1'b1;
            if (q == 2'd2) link.host_sda_oe_n <= 1'b0;
            if (q == 2'd3) begin
              link.host_scl_oe_n <= 1'b0;
              sym <= sym + 3'd1;
            end
          end
          pis_pkg::PIS_Y_STOP: begin
            if (q == 2'd0) link.host_sda_oe_n <= 1'b0;
            if (q == 2'd1) link.host_scl_oe_n <= 1'b1;
            if (q == 2'd2) link.host_sda_oe_n <= 1'b1;
            if (q == 2'd3) busy <= 1'b0;
          end
          default: begin
            if (q == 2'd0) begin
              if (bitn < 4'd8) link.host_sda_oe_n <= (kind == pis_pkg::PIS_Y_TX) ? txb[3'(4'd7 - bitn)] : 1'b1;
              else link.host_sda_oe_n <= ~((kind == pis_pkg::PIS_Y_RX) & (sym == 3'd5));
            end
            if (q == 2'd1) link.host_scl_oe_n <= 1'b1;
            if (q == 2'd2) begin
              if (bitn < 4'd8) rx <= {rx[6:0], f_sda};
              else if (kind == pis_pkg::PIS_Y_TX && f_sda) begin
                nack     <= 1'b1;
                stopping <= 1'b1;
              end
            end
            if (q == 2'd3) begin
              link.host_scl_oe_n <= 1'b0;
              bitn <= (bitn == 4'd8) ? 4'd0 : bitn + 4'd1;
              if (bitn == 4'd8) begin
                sym <= sym + 3'd1;
                if (kind == pis_pkg::PIS_Y_RX && sym == 3'd5) rdata[7:0] <= rx;
                if (kind == pis_pkg::PIS_Y_RX && sym == 3'd6) rdata[15:8] <= rx;
              end
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== pis_link_sva.sv
// assertions on the two-wire link between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module pis_link_sva #(
  parameter int QUARTER_CYC = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic [9:0] run;
  // cycles since the clock wire last changed level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      run   <= '0;
    end else begin
      scl_q <= scl;
      run   <= (scl != scl_q) ? '0 : ((run == '1) ? run : run + 10'd1);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_open_drain: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
    else $error("link wire driven high");
  chk_quiet_reset: assert property ($past(rst) |-> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n)
    else $error("link wire held after reset");
  chk_scl_half_min: assert property (scl != scl_q |-> run >= 2 * QUARTER_CYC - 2)
    else $error("clock half period too short");
  chk_dev_still_high: assert property (scl && scl_q |-> $stable(dev_sda_oe_n))
    else $error("device moved data while clock high");
  chk_host_frames: assert property (scl && scl_q && $changed(sda) |-> $changed(host_sda_oe_n))
    else $error("data edge under high clock not from host");
  chk_idle_after_stop: assert property ($rose(sda) && scl && scl_q |-> dev_sda_oe_n [*8])
    else $error("device drives after stop");
  chk_dev_take_prompt: assert property ($fell(dev_sda_oe_n) |-> !scl && run <= 8)
    else $error("device pulled data late or under high clock");
  chk_dev_drop_prompt: assert property ($rose(dev_sda_oe_n) |-> !scl && run <= 8)
    else $error("device released data late or under high clock");
  cover property ($fell(sda) && scl && scl_q);
  cover property ($fell(dev_sda_oe_n));
  cover property ($rose(sda) && scl && scl_q);
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, nv_we, dev_ready, boot_fail, pm_en, tmode, pin_used;
  logic [7:0]  nv_addr;
  logic [15:0] nv_wdata;
  logic [15:0] nv_mem [0:16];
  logic [15:0] tele [0:6];
  logic [7:0]  tcmd [0:6] = '{8'h88, 8'h89, 8'h8B, 8'h8C, 8'h8D, 8'h96, 8'h97};
  int          n_errors = 0;
  int          n_compared = 0;
  // the device answers at base plus strap offset until the offset is disabled
  logic [6:0]  dev_sa = 7'h42;
  logic [2:0]  offset_pin = 3'h2;
  pis_link_if pis_link_if_i ();
  pis_host_end #(.QUARTER_CYC(4)) pis_host_end_i (.sys_clk(sys_clk), .rst(rst),
    .link(pis_link_if_i), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp));
  pis_dev_end pis_dev_end_i (.sys_clk(sys_clk), .rst(rst), .link(pis_link_if_i),
    .address_offset_select_pin(offset_pin), .tele_vin(tele[0]), .tele_iin(tele[1]),
    .tele_vout(tele[2]), .tele_iout(tele[3]), .tele_temp(tele[4]), .tele_pout(tele[5]),
    .tele_pin(tele[6]), .nv_addr(nv_addr), .nv_we(nv_we), .nv_wdata(nv_wdata),
    .nv_rdata(nv_mem[nv_addr]), .dev_ready(dev_ready), .boot_fail(boot_fail),
    .pmbus_enabled(pm_en), .test_mode(tmode), .pin_offset_used(pin_used));
  pis_link_sva #(.QUARTER_CYC(4)) pis_link_sva_i (.sys_clk(sys_clk), .rst(rst),
    .host_scl_o(pis_link_if_i.host_scl_o), .host_scl_oe_n(pis_link_if_i.host_scl_oe_n),
    .host_sda_o(pis_link_if_i.host_sda_o), .host_sda_oe_n(pis_link_if_i.host_sda_oe_n),
    .dev_sda_o(pis_link_if_i.dev_sda_o), .dev_sda_oe_n(pis_link_if_i.dev_sda_oe_n),
    .scl(pis_link_if_i.scl), .sda(pis_link_if_i.sda));
  initial forever #2.5 sys_clk = ~sys_clk;
  // nonvolatile store model, word returned in the same cycle
  always @(posedge sys_clk) if (nv_we) nv_mem[nv_addr] <= nv_wdata;
  function automatic logic [15:0] crc16();
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < 16; i++)
      for (int b = 15; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ nv_mem[i][b]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // one link transfer through the host registers
  task automatic xfer(input logic [1:0] md, input logic [6:0] sa, input logic [7:0] c,
                      input logic [15:0] wd, output logic [15:0] rd, output logic nk);
    logic [31:0] r;
    ahb(1'b1, 8'h04, {25'h0, sa}, r);
    ahb(1'b1, 8'h08, {24'h0, c}, r);
    ahb(1'b1, 8'h0C, {16'h0, wd}, r);
    ahb(1'b1, 8'h00, {29'h0, md, 1'b1}, r);
    do ahb(1'b0, 8'h14, '0, r); while (r[0] !== 1'b0);
    nk = r[1];
    ahb(1'b0, 8'h10, '0, r);
    rd = r[15:0];
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic nk_exp);
    logic [15:0] r;
    logic        nk;
    xfer(2'd0, dev_sa, c, d, r, nk);
    check("write nack", nk_exp, nk);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] r;
    logic        nk;
    xfer(2'd1, dev_sa, c, 16'h0000, r, nk);
    check("read word", exp, r);
  endtask
  task automatic t_boot(input logic [3:0] fl);
    for (int k = 0; k < 200 && dev_ready !== 1'b1; k++)
      @(posedge sys_clk);
    check("ready", 1, dev_ready);
    check("flags", fl, {boot_fail, pm_en, tmode, pin_used});
  endtask
  task automatic t_telem;
    for (int i = 0; i < 7; i++)
      rd(tcmd[i], tele[i]);
  endtask
  task automatic t_miss_and_window;
    logic [15:0] r;
    logic        nk;
    xfer(2'd1, 7'h40, 8'h88, 16'h0000, r, nk);
    check("miss nack", 1, nk);
    xfer(2'd0, dev_sa, 8'hD0, 16'h4040, r, nk);
    rd(8'hD0, 16'h1040);
  endtask
  task automatic t_store;
    logic [15:0] r;
    logic        nk;
    wr(8'h42, 16'h0040, 1'b0);
    dev_sa = 7'h40;
    check("offset used", 0, pin_used);
    xfer(2'd2, dev_sa, 8'h15, 16'h0000, r, nk);
    check("store nack", 0, nk);
    for (int k = 0; k < 400 && nv_mem[2] !== 16'h0040; k++)
      @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    check("stored word", 16'h0040, nv_mem[2]);
    check("stored crc", crc16(), nv_mem[16]);
  endtask
  task automatic t_lock;
    wr(8'hD4, 16'h0004, 1'b0);
    wr(8'h40, 16'h2050, 1'b0);
    rd(8'h40, 16'h1040);
  endtask
  task automatic t_access;
    wr(8'hD6, 16'hBEEF, 1'b0);
    wr(8'hD5, 16'h0001, 1'b0);
    wr(8'hD7, 16'h1234, 1'b0);
    rd(8'h40, 16'hFFFF);
    wr(8'h41, 16'h0000, 1'b1);
    wr(8'hD7, 16'hBEEF, 1'b0);
    rd(8'h40, 16'h1040);
    wr(8'hD5, 16'h0004, 1'b0);
    rd(8'h40, 16'hFFFF);
    wr(8'hD5, 16'h0008, 1'b0);
    rd(8'h88, tele[0]);
    rd(8'h40, 16'hFFFF);
    wr(8'hD6, 16'h0000, 1'b1);
  endtask
  // mid-run reset: reboot from the stored image, then address and write-protect cases
  task automatic t_reboot;
    logic [15:0] r;
    logic        nk;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_boot(4'b0100);
    wr(8'h40, 16'h0040, 1'b0);
    check("test mode", 1, tmode);
    wr(8'h40, 16'h1000, 1'b0);
    check("pmbus on", 0, pm_en);
    xfer(2'd1, 7'h40, 8'h88, 16'h0000, r, nk);
    check("pmbus off nack", 1, nk);
    dev_sa = 7'h10;
    wr(8'hD5, 16'h0002, 1'b0);
    wr(8'hD6, 16'h1111, 1'b1);
    rd(8'h40, 16'h1000);
  endtask
  task automatic wrap_up;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge sys_clk);
    n_errors++;
    wrap_up;
  end
  initial begin
    for (int i = 0; i < 17; i++)
      nv_mem[i] = 16'h0000;
    for (int i = 0; i < 7; i++)
      tele[i] = {8'hA5, 8'(i)};
    nv_mem[0] = 16'h1040;
    nv_mem[16] = crc16();
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_boot(4'b0101);
    t_telem;
    t_miss_and_window;
    t_store;
    t_lock;
    t_access;
    t_reboot;
    wrap_up;
  end
endmodule
`default_nettype wire
